// file: rtl/adc_host_ctrl.v
// How it works
// R1: Saturate_select with zero offset acts plain 12-bit
// R2: Range flag marks input outside span
// R3: Device offset is zero after reset
// R4: Device adds signed offset to result
// R5: Clipping limits output to FFF..000
// R6: Unclipped mode emits out-of-range codes
// R7: Flag plus side bit give range side
// R8: Host writes offsets within -327..+327 only
// R9: Offset word: ten low bits, top zero
// R10: Mode pins 01 immediate, 10 deferred only
// R11: Immediate mode loads at conversion end
// R12: Deferred mode loads at next trigger
// R13: Host never reads during a conversion
// R14: Device drives lines only when selected
// R15: Host may keep chip select low
// R16: Host leaves idle gap before start
// R17: Trigger fall starts roughly 300 ns conversion
// R18: Busy low during conversion, rise ready
// R19: Offset field is ten-bit twos complement
// R20: Offset kept; rewrite only between conversions
// R21: Device sums in wide signed arithmetic
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "adc_host_map.vh"
module adc_host_ctrl (
  input  wire        core_clk_in,
  input  wire        nrst_in,
  input  wire        clk_en_in,
  input  wire [3:0]  addr_in,
  input  wire [15:0] wdata_in,
  input  wire        wr_in,
  input  wire        rd_in,
  output reg  [15:0] rdata_out,
  input  wire        conversion_active_n_in,
  input  wire [12:0] result_lines_in,
  output reg  [12:0] result_lines_out,
  output reg         result_lines_oe_out,
  output reg         sample_trigger_n_out,
  output reg         chip_select_n_out,
  output reg         read_strobe_n_out,
  output reg         write_strobe_n_out,
  output reg         saturate_select_out,
  output reg         iface_sel_a_out,
  output reg         iface_sel_b_out,
  output reg         busy_out
);
  // One-hot sequencer states
  localparam [6:0] S_IDLE  = 7'h01;
  localparam [6:0] S_TRIG  = 7'h02;
  localparam [6:0] S_CONV  = 7'h04;
  localparam [6:0] S_READ  = 7'h08;
  localparam [6:0] S_GAP   = 7'h10;
  localparam [6:0] S_WRITE = 7'h20;
  localparam [6:0] S_WEND  = 7'h40;

  reg  [6:0]  state_q;          // Sequencer state
  reg  [7:0]  cnt_q;            // Phase counter
  reg  [9:0]  offset_q;         // Offset shadow sent to device
  reg  [7:0]  gap_q;            // Idle gap in cycles
  reg         defer_q;          // Deferred update selected
  reg  [12:0] result_q;         // Last captured result
  reg         valid_q;          // Result captured since last read
  reg         reject_q;         // Out-of-span offset was refused
  reg         start_pend_q;     // Conversion request waiting
  reg         wr_pend_q;        // Offset write waiting
  reg         busy_seen_q;      // Device pulled busy low

  // Signed range check on a ten-bit offset
  function in_span;
    input [9:0] v;
    begin
      in_span = v[9] ? (v >= `OFFSET_MIN) : (v <= `OFFSET_MAX);
    end
  endfunction

  // Register writes and offset reject status
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      offset_q     <= `OFFSET_RESET;
      gap_q        <= `GAP_RESET;
      defer_q      <= 1'b0;
      reject_q     <= 1'b0;
      saturate_select_out <= 1'b1;
      iface_sel_a_out     <= 1'b1;
      iface_sel_b_out     <= 1'b0;
    end else if (clk_en_in) begin
      if (wr_in && addr_in == `REG_CTRL) begin
        saturate_select_out <= wdata_in[`CTRL_SAT_BIT];
        defer_q <= wdata_in[`CTRL_DEFER_BIT];
        // R10 only legal pin pairs
        iface_sel_a_out <= ~wdata_in[`CTRL_DEFER_BIT];
        iface_sel_b_out <= wdata_in[`CTRL_DEFER_BIT];
      end
      if (wr_in && addr_in == `REG_OFFSET) begin
        // R8 refuse out-of-span offsets
        if (in_span(wdata_in[9:0])) begin
          offset_q <= wdata_in[9:0];
          reject_q <= 1'b0;
        end else begin
          reject_q <= 1'b1;
        end
      end
      if (wr_in && addr_in == `REG_GAP)
        gap_q <= wdata_in[7:0];
    end
  end

  // Sequencer: trigger, wait busy, read, gap, offset write
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q              <= S_IDLE;
      cnt_q                <= 8'h00;
      result_q             <= 13'h0000;
      valid_q              <= 1'b0;
      start_pend_q         <= 1'b0;
      wr_pend_q            <= 1'b0;
      busy_seen_q          <= 1'b0;
      sample_trigger_n_out <= 1'b1;
      chip_select_n_out    <= 1'b1;
      read_strobe_n_out    <= 1'b1;
      write_strobe_n_out   <= 1'b1;
      result_lines_out     <= 13'h0000;
      result_lines_oe_out  <= 1'b0;
      busy_out             <= 1'b0;
    end else if (clk_en_in) begin
      // Requests latch; a new request beats a same-cycle consume
      if (wr_in && addr_in == `REG_CTRL && wdata_in[`CTRL_START_BIT])
        start_pend_q <= 1'b1;
      else if (state_q == S_IDLE && start_pend_q && !wr_pend_q)
        start_pend_q <= 1'b0;
      if (wr_in && addr_in == `REG_CTRL && wdata_in[`CTRL_WRITE_BIT])
        wr_pend_q <= 1'b1;
      else if (state_q == S_IDLE && wr_pend_q)
        wr_pend_q <= 1'b0;
      if (rd_in && addr_in == `REG_RESULT)
        valid_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          busy_out <= start_pend_q | wr_pend_q;
          cnt_q    <= 8'h00;
          // R20 offset write only between conversions
          if (wr_pend_q) begin
            state_q <= S_WRITE;
            chip_select_n_out   <= 1'b0;
            result_lines_out    <= {3'b000, offset_q};
            result_lines_oe_out <= 1'b1;
          end else if (start_pend_q) begin
            // R17 falling trigger starts conversion
            state_q <= S_TRIG;
            sample_trigger_n_out <= 1'b0;
            busy_seen_q <= 1'b0;
          end
        end
        S_TRIG: begin
          if (!conversion_active_n_in)
            busy_seen_q <= 1'b1;
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q + 8'h01 >= `TRIG_CYCLES) begin
            sample_trigger_n_out <= 1'b1;
            state_q <= S_CONV;
            cnt_q   <= 8'h00;
          end
        end
        S_CONV: begin
          // R13 no read until busy rises
          cnt_q <= cnt_q + 8'h01;
          if (!conversion_active_n_in)
            busy_seen_q <= 1'b1;
          if ((busy_seen_q || cnt_q >= `CONV_CYCLES) && conversion_active_n_in) begin
            // R15 select and strobe together
            chip_select_n_out <= 1'b0;
            read_strobe_n_out <= 1'b0;
            state_q <= S_READ;
          end
        end
        S_READ: begin
          // R14 sample lines one cycle after strobe
          result_q <= result_lines_in;
          valid_q  <= 1'b1;
          chip_select_n_out <= 1'b1;
          read_strobe_n_out <= 1'b1;
          state_q <= S_GAP;
          cnt_q   <= 8'h00;
        end
        S_GAP: begin
          // R16 quiet bus before next start
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q >= gap_q)
            state_q <= S_IDLE;
        end
        S_WRITE: begin
          // R9 top three bits driven zero
          write_strobe_n_out <= 1'b0;
          state_q <= S_WEND;
        end
        S_WEND: begin
          write_strobe_n_out  <= 1'b1;
          chip_select_n_out   <= 1'b1;
          result_lines_oe_out <= 1'b0;
          state_q <= S_GAP;
          cnt_q   <= 8'h00;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Read port, data valid the cycle after the strobe
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= 16'h0000;
    end else if (clk_en_in) begin
      if (rd_in) begin
        case (addr_in)
          `REG_CTRL:   rdata_out <= {12'h000, 1'b0, defer_q, saturate_select_out, 1'b0};
          `REG_OFFSET: rdata_out <= {6'h00, offset_q};
          `REG_STATUS: rdata_out <= {12'h000, reject_q, valid_q,
                                     ~conversion_active_n_in, busy_out};
          `REG_RESULT: rdata_out <= {3'b000, result_q};
          `REG_GAP:    rdata_out <= {8'h00, gap_q};
          default:     rdata_out <= 16'h0000;
        endcase
      end else begin
        rdata_out <= 16'h0000;
      end
    end
  end
endmodule // adc_host_ctrl

// file: rtl/adc_host_map.vh
`ifndef ADC_HOST_MAP_VH
`define ADC_HOST_MAP_VH
// Controller register offsets (word index on the command port)
`define REG_CTRL        4'h0
`define REG_OFFSET      4'h1
`define REG_STATUS      4'h2
`define REG_RESULT      4'h3
`define REG_GAP         4'h4
// Control register fields
`define CTRL_START_BIT  0
`define CTRL_SAT_BIT    1
`define CTRL_DEFER_BIT  2
`define CTRL_WRITE_BIT  3
// Reset values
`define CTRL_RESET      8'h02
`define OFFSET_RESET    10'h000
// Offset limits accepted from software
`define OFFSET_MAX      10'h147
`define OFFSET_MIN      10'h2B9
// Timing, in ns and derived clock counts at 25 MHz
`define CLK_PERIOD_NS   40
`define CONV_NS         300
`define CONV_CYCLES     ((`CONV_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TRIG_NS         40
`define TRIG_CYCLES     ((`TRIG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GAP_RESET       8'h02
`define RESULT_W        13
`endif

// file: testbench/adc_dev_model.sv
`timescale 1ns/1ps
module adc_dev_model (
  input  wire               sample_trigger_n,
  input  wire               chip_select_n,
  input  wire               read_strobe_n,
  input  wire               write_strobe_n,
  input  wire               saturate_select,
  input  wire               iface_sel_a,
  input  wire        [12:0] host_lines,
  input  wire               host_oe,
  input  wire signed [13:0] vin,
  output reg                conversion_active_n,
  output wire        [12:0] bus_level
);
  reg signed [9:0]  ofs_q = 10'sh000;
  reg        [12:0] out_q = 13'h0000;
  reg        [12:0] new_q = 13'h0000;
  reg signed [13:0] sum;
  initial conversion_active_n = 1'b1;
  always @(negedge sample_trigger_n) begin
    if (!iface_sel_a) out_q = new_q;
    conversion_active_n = 1'b0;
    #300;
    sum = vin + ofs_q;
    new_q = saturate_select ? {vin < 0 || vin > 4095,
      sum < 0 ? 12'h000 : sum > 4095 ? 12'hFFF : sum[11:0]} : sum[12:0];
    if (iface_sel_a) out_q = new_q;
    conversion_active_n = 1'b1;
  end
  always @(negedge write_strobe_n) if (!chip_select_n && host_oe) ofs_q = host_lines[9:0];
  assign bus_level = host_oe ? host_lines : (!chip_select_n && !read_strobe_n) ? out_q : ~out_q;
endmodule // adc_dev_model

// file: testbench/adc_host_ctrl_asserts.sv
`timescale 1ns/1ps
module adc_host_ctrl_chk (
  input wire        core_clk_in,
  input wire        nrst_in,
  input wire        conversion_active_n_in,
  input wire [12:0] result_lines_out,
  input wire        result_lines_oe_out,
  input wire        sample_trigger_n_out,
  input wire        chip_select_n_out,
  input wire        read_strobe_n_out,
  input wire        write_strobe_n_out,
  input wire        iface_sel_a_out,
  input wire        iface_sel_b_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  // Read and offset-write strobe phases
  sequence s_rd_low; !read_strobe_n_out && !chip_select_n_out; endsequence
  sequence s_wr_low; !write_strobe_n_out && !chip_select_n_out && result_lines_oe_out; endsequence
  chk_mode_legal: assert property (iface_sel_a_out != iface_sel_b_out)
    else $error("mode pins illegal");
  chk_offset_top: assert property (result_lines_oe_out |-> result_lines_out[12:10] == 3'h0)
    else $error("offset top bits set");
  chk_offset_span: assert property (result_lines_oe_out |->
    $signed(result_lines_out[9:0]) >= -327 && $signed(result_lines_out[9:0]) <= 327)
    else $error("offset out of span");
  chk_read_idle: assert property (!read_strobe_n_out |-> conversion_active_n_in)
    else $error("read during conversion");
  chk_read_pulse: assert property ($fell(read_strobe_n_out) |-> s_rd_low ##1 read_strobe_n_out)
    else $error("read strobe frame");
  chk_write_pulse: assert property ($fell(write_strobe_n_out) |-> s_wr_low ##1 !result_lines_oe_out)
    else $error("write strobe frame");
  chk_trig_pulse: assert property ($fell(sample_trigger_n_out) |=> sample_trigger_n_out)
    else $error("trigger pulse length");
  chk_idle_gap: assert property ($rose(chip_select_n_out) |-> sample_trigger_n_out[*3])
    else $error("idle gap too short");
endmodule // adc_host_ctrl_chk
bind adc_host_ctrl adc_host_ctrl_chk chk_i (.*);

// file: testbench/tb_top.sv
`timescale 1ns/1ps
`include "adc_host_map.vh"
module tb_top;
  reg         core_clk_in, nrst_in, wr_in, rd_in, clk_en_in;
  reg  [3:0]  addr_in;
  reg  [15:0] wdata_in;
  reg  signed [13:0] vin;
  reg  [12:0] prev = 13'h0000;
  wire [15:0] rdata_out;
  wire [12:0] lines, dev_lines;
  wire        oe, trig_n, cs_n, rd_n, wr_n, sat, sel_a, sel_b, busy, conv_n;
  integer     miscompares = 0, samples_checked = 0, cycles = 0, i;
  adc_host_ctrl uut (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .clk_en_in(clk_en_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .conversion_active_n_in(conv_n), .result_lines_in(dev_lines), .result_lines_out(lines),
    .result_lines_oe_out(oe), .sample_trigger_n_out(trig_n), .chip_select_n_out(cs_n),
    .read_strobe_n_out(rd_n), .write_strobe_n_out(wr_n), .saturate_select_out(sat),
    .iface_sel_a_out(sel_a), .iface_sel_b_out(sel_b), .busy_out(busy));
  adc_dev_model dev (.sample_trigger_n(trig_n), .chip_select_n(cs_n), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .saturate_select(sat), .iface_sel_a(sel_a), .host_lines(lines),
    .host_oe(oe), .vin(vin), .conversion_active_n(conv_n), .bus_level(dev_lines));
  task check(input string name, input [15:0] seen, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task bus_wr(input [3:0] a, input [15:0] d);
    begin
      @(posedge core_clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge core_clk_in);
      wr_in <= 1'b0;
    end
  endtask
  task bus_rd(input [3:0] a, input [15:0] e, input string name);
    begin
      @(posedge core_clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge core_clk_in);
      rd_in <= 1'b0;
      #1 check(name, rdata_out, e);
    end
  endtask
  // Wait for the sequencer to finish, bounded
  task settle;
    begin
      repeat (3) @(posedge core_clk_in);
      for (i = 0; i < 60 && busy !== 1'b0; i = i + 1) @(posedge core_clk_in);
    end
  endtask
  // Mode bits: start, saturate, deferred
  task conv(input signed [13:0] v, input [2:0] m, input [12:0] e);
    begin
      vin <= v;
      bus_wr(`REG_CTRL, {13'h0000, m});
      settle;
      bus_rd(`REG_RESULT, {3'h0, m[2] ? prev : e}, "result");
      prev = e;
      $display("conversion test done, input %0d", v);
    end
  endtask
  task ofs(input [15:0] d);
    begin
      bus_wr(`REG_OFFSET, d);
      bus_wr(`REG_CTRL, 16'h000A);
      settle;
      $display("offset write test done");
    end
  endtask
  task summarize;
    begin
      $display("checked %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end
  // Hang guard
  always @(posedge core_clk_in) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      summarize;
    end
  end
  initial begin
    {nrst_in, wr_in, rd_in, addr_in, wdata_in, vin} = 0;
    clk_en_in = 1'b1;
    repeat (5) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    bus_rd(`REG_CTRL, 16'h0002, "ctrl");
    bus_rd(`REG_GAP, 16'h0002, "gap");
    bus_rd(4'hF, 16'h0000, "unmapped");
    // Frozen clock enable must swallow a register write
    @(posedge core_clk_in);
    clk_en_in <= 1'b0;
    bus_wr(`REG_GAP, 16'h0005);
    clk_en_in <= 1'b1;
    bus_rd(`REG_GAP, 16'h0002, "gap frozen");
    $display("freeze test done");
    // Status shows both busy bits mid-conversion, then valid
    vin <= 14'sd100;
    bus_wr(`REG_CTRL, 16'h0003);
    bus_rd(`REG_STATUS, 16'h0003, "status busy");
    settle;
    bus_rd(`REG_STATUS, 16'h0004, "status valid");
    $display("status test done");
    conv(100, 3'b011, 13'h0064);
    conv(4200, 3'b011, 13'h1FFF);
    conv(-50, 3'b011, 13'h1000);
    ofs(16'h0100);
    conv(3839, 3'b011, 13'h0FFF);
    conv(-256, 3'b011, 13'h1000);
    conv(4424, 3'b001, 13'h1248);
    conv(-328, 3'b001, 13'h1FB8);
    bus_wr(`REG_OFFSET, 16'h0148);
    bus_rd(`REG_STATUS, 16'h0008, "status");
    conv(0, 3'b001, 13'h0100);
    ofs(16'h0380);
    conv(-328, 3'b001, 13'h1E38);
    conv(100, 3'b011, 13'h0000);
    conv(500, 3'b111, 13'h0174);
    conv(600, 3'b111, 13'h01D8);
    conv(700, 3'b011, 13'h023C);
    summarize;
  end
endmodule // tb_top
